// [logic/dfic_defs.svh]
`ifndef DFIC_DEFS_SVH
`define DFIC_DEFS_SVH

// Register byte offsets
`define DFIC_OFF_COMMAND   12'h000
`define DFIC_OFF_FEATURE   12'h004
`define DFIC_OFF_STATUS    12'h008
`define DFIC_OFF_ERROR     12'h00c
`define DFIC_OFF_DATA      12'h010
`define DFIC_OFF_IRQ_STAT  12'h014
`define DFIC_OFF_IRQ_MASK  12'h018
`define DFIC_OFF_CONFIG    12'h01c
`define DFIC_OFF_MEDIA     12'h020

// Opcodes and feature
`define DFIC_OP_FORMAT     8'hf7
`define DFIC_OP_ERASE_PREP 8'hf3
`define DFIC_OP_IDENTIFY   8'hec
`define DFIC_FEAT_FORMAT   8'h11

// Status bits
`define DFIC_ST_BUSY       7
`define DFIC_ST_READY      6
`define DFIC_ST_FAULT      5
`define DFIC_ST_SEEK       4
`define DFIC_ST_DATA_REQ   3
`define DFIC_ST_ERR        0
// Error bits
`define DFIC_ER_UNCORR     6
`define DFIC_ER_NO_ID      4
`define DFIC_ER_ABORT      2

// Interrupt status bits
`define DFIC_IRQ_DONE      0
`define DFIC_IRQ_DATA_REQ  1
`define DFIC_IRQ_ABORT     2

// Identify words
`define DFIC_W0_FIXED      16'h045a
`define DFIC_W0_FIXED_ALT  16'h045e
`define DFIC_W2_SF_INC     16'h37c8
`define DFIC_W2_SF_CMP     16'h738c
`define DFIC_W2_NSF_INC    16'h8c73
`define DFIC_W2_NSF_CMP    16'hc837
`define DFIC_W6_SPT        16'h003f
`define DFIC_W20_CTRL      16'h0003
`define DFIC_W21_BUF64M    16'h0000
`define DFIC_W22_VAL       16'h0038
`define DFIC_W47_HI        8'h80
`define DFIC_W48_VAL       16'h4000
`define DFIC_ID_WORDS      256

`endif

// [logic/dfic_pkg.sv]
`default_nettype none
package dfic_pkg;
   typedef enum logic [2:0] {
      DFIC_IDLE,
      DFIC_FMT_MERGE,
      DFIC_FMT_CLEAR,
      DFIC_FMT_SECT,
      DFIC_ID_XFER,
      DFIC_DONE
   } dfic_state_t;

   typedef struct packed {
      logic        busy;
      logic        data_request_flag;
      logic        err;
      logic        abort;
      logic        erase_armed;
   } dfic_flags_t;

   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic        sel;
   } dfic_bus_req_t;
endpackage
`default_nettype wire

// [logic/dfic_core.sv]
// Functional notes
// - Format opcode F7h; feature must be 11h, others reserved and aborted.
// - Format without erase-prepare directly before it is aborted with abort error.
// - Format walks every sector from LBA 0 to native max, ignoring limits.
// - Merge reassign list into defects, clear reassign list, before sector init.
// - Format never raises data request; completes with status and error only.
// - Identify ECh returns exactly one sector of words by data-in.
// - Word 0 reads 045Ah or 045Eh: ATA, fixed, non-removable.
// - Word 2 encodes spin-up need and completeness with four codes.
// - Word 6 reads 003Fh; words 7 and 8 read zero.
// - Word 20 reads 0003h.
// - Word 21 is buffer size in 512-byte units; 64MB reads zero.
// - Serial 10-19, firmware 23-26, model 27-46 as ASCII words.
// - Word 47 high byte 80h, low byte max sectors per interrupt.
// - Word 48 reads 4000h.
// - Words 4, 5, 9 read zero; word 22 reads 0038h.
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`include "dfic_defs.svh"
`default_nettype none
module dfic_core #(
   parameter int          LBA_W       = 32,
   parameter logic [31:0] NATIVE_MAX  = 32'h0000_00ff,
   parameter logic [7:0]  MULT_SECT   = 8'h10,
   parameter logic [15:0] CYLINDERS   = 16'h3fff,
   parameter logic [15:0] HEADS       = 16'h0010,
   parameter logic [15:0] BUF_UNITS   = 16'h0000
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Interrupt
   output logic             irq,
   // Media engine view
   output logic             media_write,
   output logic [LBA_W-1:0] media_lba
);

   dfic_pkg::dfic_state_t   state,  next_state;
   dfic_pkg::dfic_flags_t   flags,  next_flags;
   dfic_pkg::dfic_bus_req_t req,    next_req;
   logic [7:0]       feature,    next_feature;
   logic [7:0]       err_reg,    next_err_reg;
   logic [7:0]       word_idx,   next_word_idx;
   logic [LBA_W-1:0] lba,        next_lba;
   logic [15:0]      reassign,   next_reassign;
   logic [15:0]      defects,    next_defects;
   logic [2:0]       irq_stat,   next_irq_stat;
   logic [2:0]       irq_mask,   next_irq_mask;
   logic [2:0]       irq_set,    irq_clr;
   logic [1:0]       cfg,        next_cfg;
   logic [31:0]      next_hrdata;
   logic             next_irq;
   logic             next_media_write;
   logic [LBA_W-1:0] next_media_lba;

   // ASCII strings as ordinary words; content is arbitrary filler
   function automatic logic [15:0] ascii_word(input logic [7:0] idx);
      logic [15:0] w;
      w = 16'h2020;
      if (idx >= 8'd10 && idx <= 8'd19) begin
         w = 16'h3030 + {8'h00, 8'(idx - 8'd10)};
      end else if (idx >= 8'd23 && idx <= 8'd26) begin
         w = 16'h3130 + {8'h00, 8'(idx - 8'd23)};
      end else if (idx >= 8'd27 && idx <= 8'd46) begin
         w = 16'h4120 + {8'(idx - 8'd27), 8'h00};
      end
      return w;
   endfunction

   // Identify word lookup
   function automatic logic [15:0] id_word(input logic [7:0] idx,
                                           input logic [1:0] c);
      logic [15:0] w;
      w = 16'h0000;
      case (idx)
         8'd0:    w = c[1] ? `DFIC_W0_FIXED_ALT : `DFIC_W0_FIXED;
         8'd1:    w = CYLINDERS;
         8'd2: begin
            case (c)
               2'b00:   w = `DFIC_W2_NSF_CMP;
               2'b01:   w = `DFIC_W2_NSF_INC;
               2'b10:   w = `DFIC_W2_SF_CMP;
               default: w = `DFIC_W2_SF_INC;
            endcase
         end
         8'd3:    w = HEADS;
         8'd6:    w = `DFIC_W6_SPT;
         8'd20:   w = `DFIC_W20_CTRL;
         8'd21:   w = BUF_UNITS;
         8'd22:   w = `DFIC_W22_VAL;
         8'd47:   w = {`DFIC_W47_HI, MULT_SECT};
         8'd48:   w = `DFIC_W48_VAL;
         default: begin
            if ((idx >= 8'd10 && idx <= 8'd19) || (idx >= 8'd23 && idx <= 8'd46)) begin
               w = ascii_word(idx);
            end
         end
      endcase
      // Words 4,5,7,8,9 and the rest fall to zero
      return w;
   endfunction

   function automatic logic [7:0] status_byte(input dfic_pkg::dfic_flags_t f);
      logic [7:0] s;
      s = 8'h00;
      s[`DFIC_ST_BUSY]  = f.busy;
      s[`DFIC_ST_READY] = 1'b1;
      s[`DFIC_ST_SEEK]  = ~f.busy;
      // No media feedback input here, so a device fault can never be raised
      s[`DFIC_ST_FAULT] = 1'b0;
      s[`DFIC_ST_DATA_REQ] = f.data_request_flag;
      s[`DFIC_ST_ERR]   = f.err;
      return s;
   endfunction

   // Registers sit in the low 4 KB, word aligned; the rest reads zero
   function automatic logic in_window(input logic [31:0] a);
      return (a[31:12] == 20'h00000) && (a[1:0] == 2'b00);
   endfunction

   logic        addr_phase;
   logic        addr_ok;
   logic        rd_data_now;
   logic        wr_cmd;
   logic [7:0]  cmd_byte;

   always_comb begin
      // Sub-word transfers are not decoded; every register is a whole word
      addr_phase  = hsel && hready && htrans[1] && (hsize == 3'b010);
      addr_ok     = req.sel && in_window(req.addr);
      wr_cmd      = addr_ok && req.write && (req.addr[11:0] == `DFIC_OFF_COMMAND);
      rd_data_now = addr_ok && !req.write && (req.addr[11:0] == `DFIC_OFF_DATA);
      cmd_byte    = hwdata[7:0];
   end

   always_comb begin
      next_state       = state;
      next_flags       = flags;
      next_req         = '0;
      next_feature     = feature;
      next_err_reg     = err_reg;
      next_word_idx    = word_idx;
      next_lba         = lba;
      next_reassign    = reassign;
      next_defects     = defects;
      irq_set          = 3'h0;
      irq_clr          = 3'h0;
      next_irq_mask    = irq_mask;
      next_cfg         = cfg;
      next_hrdata      = 32'h0000_0000;
      next_media_write = 1'b0;
      next_media_lba   = media_lba;

      // Address phase capture; slave never waits
      if (addr_phase) begin
         next_req.sel   = 1'b1;
         next_req.write = hwrite;
         next_req.addr  = haddr;
         if (!hwrite && in_window(haddr)) begin
            case (haddr[11:0])
               `DFIC_OFF_FEATURE:  next_hrdata = {24'h0, feature};
               `DFIC_OFF_STATUS:   next_hrdata = {24'h0, status_byte(flags)};
               `DFIC_OFF_ERROR:    next_hrdata = {24'h0, err_reg};
               `DFIC_OFF_DATA:     next_hrdata = flags.data_request_flag ?
                                                 {16'h0, id_word(word_idx, cfg)} : 32'h0;
               `DFIC_OFF_IRQ_STAT: next_hrdata = {29'h0, irq_stat};
               `DFIC_OFF_IRQ_MASK: next_hrdata = {29'h0, irq_mask};
               `DFIC_OFF_CONFIG:   next_hrdata = {30'h0, cfg};
               `DFIC_OFF_MEDIA:    next_hrdata = {reassign, defects};
               default:            next_hrdata = 32'h0;
            endcase
         end
      end

      // Data-phase writes
      if (addr_ok && req.write) begin
         case (req.addr[11:0])
            `DFIC_OFF_FEATURE:  next_feature  = hwdata[7:0];
            `DFIC_OFF_IRQ_MASK: next_irq_mask = hwdata[2:0];
            `DFIC_OFF_CONFIG:   next_cfg      = hwdata[1:0];
            // Models reassignments gathered by other commands
            `DFIC_OFF_MEDIA:    next_reassign = hwdata[31:16];
            default: ;
         endcase
         if (req.addr[11:0] == `DFIC_OFF_IRQ_STAT) begin
            irq_clr = hwdata[2:0];
         end
      end

      case (state)
         dfic_pkg::DFIC_IDLE: begin
            // Commands while busy are ignored
            if (wr_cmd) begin
               next_err_reg  = 8'h00;
               next_flags.err = 1'b0;
               case (cmd_byte)
                  `DFIC_OP_ERASE_PREP: begin
                     next_flags.erase_armed = 1'b1;
                     next_state = dfic_pkg::DFIC_DONE;
                  end
                  `DFIC_OP_FORMAT: begin
                     next_flags.erase_armed = 1'b0;
                     if (!flags.erase_armed || feature != `DFIC_FEAT_FORMAT) begin
                        next_flags.abort = 1'b1;
                        next_state = dfic_pkg::DFIC_DONE;
                     end else begin
                        next_flags.busy = 1'b1;
                        next_state = dfic_pkg::DFIC_FMT_MERGE;
                     end
                  end
                  `DFIC_OP_IDENTIFY: begin
                     next_flags.erase_armed = 1'b0;
                     next_word_idx = 8'h00;
                     next_flags.data_request_flag = 1'b1;
                     irq_set[`DFIC_IRQ_DATA_REQ] = 1'b1;
                     next_state = dfic_pkg::DFIC_ID_XFER;
                  end
                  default: begin
                     // Any other command breaks the erase-prepare pairing
                     next_flags.erase_armed = 1'b0;
                     next_flags.abort = 1'b1;
                     next_state = dfic_pkg::DFIC_DONE;
                  end
               endcase
            end
         end
         dfic_pkg::DFIC_FMT_MERGE: begin
            next_defects = defects | reassign;
            next_state   = dfic_pkg::DFIC_FMT_CLEAR;
         end
         dfic_pkg::DFIC_FMT_CLEAR: begin
            next_reassign = 16'h0000;
            next_lba      = '0;
            next_state    = dfic_pkg::DFIC_FMT_SECT;
         end
         dfic_pkg::DFIC_FMT_SECT: begin
            // Native max, not any host-set limit; data request stays low
            next_media_write = 1'b1;
            next_media_lba   = lba;
            next_lba         = lba + 1'b1;
            if (lba == NATIVE_MAX[LBA_W-1:0]) begin
               next_flags.busy = 1'b0;
               next_state = dfic_pkg::DFIC_DONE;
            end
         end
         dfic_pkg::DFIC_ID_XFER: begin
            if (rd_data_now) begin
               next_word_idx = word_idx + 8'd1;
               if (word_idx == 8'(`DFIC_ID_WORDS - 1)) begin
                  next_flags.data_request_flag = 1'b0;
                  next_state = dfic_pkg::DFIC_DONE;
               end
            end
         end
         dfic_pkg::DFIC_DONE: begin
            next_flags.busy = 1'b0;
            next_flags.data_request_flag = 1'b0;
            if (flags.abort) begin
               next_err_reg[`DFIC_ER_ABORT] = 1'b1;
               next_flags.err = 1'b1;
               irq_set[`DFIC_IRQ_ABORT] = 1'b1;
            end
            next_flags.abort = 1'b0;
            irq_set[`DFIC_IRQ_DONE] = 1'b1;
            next_state = dfic_pkg::DFIC_IDLE;
         end
         default: next_state = dfic_pkg::DFIC_IDLE;
      endcase
   end

   // Sticky events; a set in the same cycle as its write-one clear wins
   for (genvar i = 0; i < 3; i++) begin : g_irq
      assign next_irq_stat[i] = irq_set[i] | (irq_stat[i] & ~irq_clr[i]);
   end
   assign next_irq = |(next_irq_stat & irq_mask);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state       <= dfic_pkg::DFIC_IDLE;
         flags       <= '0;
         req         <= '0;
         feature     <= 8'h00;
         err_reg     <= 8'h00;
         word_idx    <= 8'h00;
         lba         <= '0;
         reassign    <= 16'h0000;
         defects     <= 16'h0000;
         irq_stat    <= 3'h0;
         irq_mask    <= 3'h0;
         cfg         <= 2'h0;
         hrdata      <= 32'h0000_0000;
         irq         <= 1'b0;
         media_write <= 1'b0;
         media_lba   <= '0;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         state       <= next_state;
         flags       <= next_flags;
         req         <= next_req;
         feature     <= next_feature;
         err_reg     <= next_err_reg;
         word_idx    <= next_word_idx;
         lba         <= next_lba;
         reassign    <= next_reassign;
         defects     <= next_defects;
         irq_stat    <= next_irq_stat;
         irq_mask    <= next_irq_mask;
         cfg         <= next_cfg;
         hrdata      <= next_hrdata;
         irq         <= next_irq;
         media_write <= next_media_write;
         media_lba   <= next_media_lba;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [sim/dfic_core_assertions.sv]
`include "dfic_defs.svh"
`default_nettype none
module dfic_core_checker #(
   parameter int          LBA_W      = 32,
   parameter logic [31:0] NATIVE_MAX = 32'h0000_00ff
) (
   // Clock and reset
   input wire logic             hclk,
   input wire logic             hresetn,
   // Bus
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [2:0]       hsize,
   input wire logic [31:0]      hwdata,
   input wire logic             hready,
   input wire logic [31:0]      hrdata,
   input wire logic             hreadyout,
   input wire logic             hresp,
   // Interrupt and media
   input wire logic             irq,
   input wire logic             media_write,
   input wire logic [LBA_W-1:0] media_lba
);
   logic        dp_rd;
   logic        dp_wr;
   logic [11:0] dp_adr;
   logic [8:0]  idx;
   logic [31:0] fcnt;
   logic        fmt_on;
   logic        rd_st;
   logic        rd_dt;
   assign rd_st = dp_rd && dp_adr == `DFIC_OFF_STATUS;
   assign rd_dt = dp_rd && dp_adr == `DFIC_OFF_DATA;
   // Word index and sector count restart at every command write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_rd <= 1'b0;
         dp_wr <= 1'b0;
         dp_adr <= 12'h000;
         idx <= 9'h000;
         fcnt <= 32'h0000_0000;
         fmt_on <= 1'b0;
      end else begin
         dp_rd <= hsel & hready & htrans[1] & ~hwrite;
         dp_wr <= hsel & hready & htrans[1] & hwrite;
         dp_adr <= haddr[11:0];
         if (dp_wr && dp_adr == `DFIC_OFF_COMMAND) begin
            idx <= 9'h000;
            fcnt <= 32'h0000_0000;
            fmt_on <= 1'b0;
         end else begin
            if (rd_dt) idx <= idx + 9'h001;
            if (media_write) fcnt <= fcnt + 32'h0000_0001;
            if (media_write) fmt_on <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_lba_seq; media_write |-> media_lba == fcnt[LBA_W-1:0]; endproperty
   a_lba_seq: assert property (p_lba_seq) else $error("sector out of order");
   property p_lba_max; media_write |-> fcnt <= NATIVE_MAX; endproperty
   a_lba_max: assert property (p_lba_max) else $error("sector past native max");
   property p_no_dreq_fmt; rd_st && fmt_on |-> !hrdata[3]; endproperty
   a_no_dreq_fmt: assert property (p_no_dreq_fmt) else $error("data request in format");
   property p_dreq_busy; rd_st && hrdata[3] |-> !hrdata[7]; endproperty
   a_dreq_busy: assert property (p_dreq_busy) else $error("busy with data request");
   property p_dreq_cnt; rd_st && hrdata[3] |-> idx < 9'd256; endproperty
   a_dreq_cnt: assert property (p_dreq_cnt) else $error("data request past sector");
   property p_w2;
      rd_dt && idx == 2 |-> hrdata[15:0] inside {16'h37c8, 16'h738c, 16'h8c73, 16'hc837};
   endproperty
   a_w2: assert property (p_w2) else $error("word 2 wrong");
   property p_w_zero; rd_dt && idx inside {4, 5, 9} |-> hrdata[15:0] == 16'h0000; endproperty
   a_w_zero: assert property (p_w_zero) else $error("reserved word not zero");
   property p_w22; rd_dt && idx == 22 |-> hrdata[15:0] == 16'h0038; endproperty
   a_w22: assert property (p_w22) else $error("word 22 wrong");
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("slave not ready or not okay");
   property p_w0; rd_dt && idx == 0 |-> hrdata[15:0] inside {16'h045a, 16'h045e}; endproperty
   a_w0: assert property (p_w0) else $error("word 0 wrong");
   property p_w6; rd_dt && idx == 6 |-> hrdata[15:0] == 16'h003f; endproperty
   a_w6: assert property (p_w6) else $error("word 6 wrong");
   property p_w78; rd_dt && (idx == 7 || idx == 8) |-> hrdata[15:0] == 16'h0000; endproperty
   a_w78: assert property (p_w78) else $error("word 7 or 8 wrong");
   property p_w20; rd_dt && idx == 20 |-> hrdata[15:0] == 16'h0003; endproperty
   a_w20: assert property (p_w20) else $error("word 20 wrong");
   property p_w47; rd_dt && idx == 47 |-> hrdata[15:8] == 8'h80; endproperty
   a_w47: assert property (p_w47) else $error("word 47 wrong");
   property p_w48; rd_dt && idx == 48 |-> hrdata[15:0] == 16'h4000; endproperty
   a_w48: assert property (p_w48) else $error("word 48 wrong");
endmodule
bind dfic_core dfic_core_checker #(.LBA_W(LBA_W), .NATIVE_MAX(NATIVE_MAX)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .media_write(media_write),
   .media_lba(media_lba));
`default_nettype wire

// [sim/dfic_host_model.sv]
`include "dfic_defs.svh"
`default_nettype none
module dfic_host_model (
   // Clock and slave answer
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // Request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
   end
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      // Released address toggles so a stale value is never trusted
      haddr <= ~a;
      hwdata <= w ? d : ~d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] feat);
      logic [31:0] r;
      xfer(1'b1, `DFIC_OFF_FEATURE, {24'h000000, feat}, r);
      xfer(1'b1, `DFIC_OFF_COMMAND, {24'h000000, op}, r);
   endtask
endmodule
`default_nettype wire

// [sim/test_disk_format_identify_cmds.sv]
`include "dfic_defs.svh"
`default_nettype none
module test_disk_format_identify_cmds;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic        media_write;
   logic [31:0] media_lba;
   logic [31:0] r;
   logic [16:0] e;
   logic [7:0]  v;
   logic [15:0] ra;
   int          n_fail;
   int          check_count;
   int          n_pulse = 0;
   dfic_core #(.NATIVE_MAX(32'h0000_0007)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .media_write(media_write), .media_lba(media_lba));
   dfic_host_model u_host (
      .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   always #4 hclk = ~hclk;
   always @(posedge hclk) if (media_write === 1'b1) n_pulse <= n_pulse + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results;
      if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [11:0] a);
      u_host.xfer(1'b0, {20'h00000, a}, 32'h0000_0000, r);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, {20'h00000, a}, d, r);
   endtask
   task automatic wait_idle;
      for (int k = 0; k < 1000; k++) begin
         rd(`DFIC_OFF_STATUS);
         if (r[7] === 1'b0) break;
      end
      chk(r[7], 1'b0);
   endtask
   function automatic logic [16:0] id_exp(input int i, input logic [1:0] c);
      case (i)
         0: return {1'b1, c[1] ? 16'h045e : 16'h045a};
         2: return {1'b1, c == 2'b00 ? 16'hc837 : c == 2'b01 ? 16'h8c73 :
                          c == 2'b10 ? 16'h738c : 16'h37c8};
         4, 5, 7, 8, 9, 21: return {1'b1, 16'h0000};
         6: return {1'b1, 16'h003f};
         20: return {1'b1, 16'h0003};
         22: return {1'b1, 16'h0038};
         47: return {1'b1, 16'h8010};
         48: return {1'b1, 16'h4000};
         default: return 17'h00000;
      endcase
   endfunction
   function automatic logic [1:0] ascii_pair(input logic [15:0] w);
      return {w[15:8] inside {[8'h20:8'h7e]}, w[7:0] inside {[8'h20:8'h7e]}};
   endfunction
   initial begin
      // Large margin, as a real host scales it with capacity
      #(8 * 40000);
      n_fail = n_fail + 1;
      results;
   end
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      n_fail = 0;
      check_count = 0;
      void'($urandom(50));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`DFIC_OFF_STATUS);
      chk(r[7:0], 8'h50);
      rd(12'h040);
      chk(r, 32'h0000_0000);
      rd(`DFIC_OFF_IRQ_STAT);
      chk(r, 32'h0000_0000);
      for (int c = 0; c < 4; c++) begin
         wr(`DFIC_OFF_CONFIG, c);
         wr(`DFIC_OFF_IRQ_MASK, 32'h0000_0007);
         wr(`DFIC_OFF_IRQ_STAT, 32'h0000_0007);
         u_host.cmd(`DFIC_OP_IDENTIFY, 8'h00);
         rd(`DFIC_OFF_STATUS);
         chk({r[7], r[3]}, 2'b01);
         for (int i = 0; i < 256; i++) begin
            rd(`DFIC_OFF_DATA);
            e = id_exp(i, c[1:0]);
            if (e[16]) chk(r[15:0], e[15:0]);
            if (i inside {[10:19], [23:46]}) chk(ascii_pair(r[15:0]), 2'b11);
         end
         rd(`DFIC_OFF_STATUS);
         chk(r[3], 1'b0);
         rd(`DFIC_OFF_IRQ_STAT);
         chk(r[2:0], 3'b011);
         chk(irq, 1'b1);
         wr(`DFIC_OFF_IRQ_MASK, 32'h0000_0000);
         repeat (2) @(posedge hclk);
         #1 chk(irq, 1'b0);
         wr(`DFIC_OFF_IRQ_MASK, 32'h0000_0007);
         wr(`DFIC_OFF_IRQ_STAT, 32'h0000_0007);
         repeat (2) @(posedge hclk);
         #1 chk(irq, 1'b0);
      end
      // Missing prepare, a stray command between, then a reserved feature
      for (int k = 0; k < 3; k++) begin
         v = 8'($urandom);
         if (k == 1 && v inside {8'hf3, 8'hf7, 8'hec}) v = 8'h00;
         if (k == 2 && v == 8'h11) v = 8'h12;
         if (k > 0) u_host.cmd(`DFIC_OP_ERASE_PREP, 8'h00);
         wait_idle;
         if (k == 1) u_host.cmd(v, 8'h00);
         wait_idle;
         u_host.cmd(`DFIC_OP_FORMAT, k == 2 ? v : `DFIC_FEAT_FORMAT);
         wait_idle;
         rd(`DFIC_OFF_ERROR);
         chk(r[2], 1'b1);
         chk(n_pulse, 0);
      end
      ra = 16'($urandom) | 16'h0001;
      wr(`DFIC_OFF_MEDIA, {ra, 16'h0000});
      wr(`DFIC_OFF_IRQ_STAT, 32'h0000_0007);
      u_host.cmd(`DFIC_OP_ERASE_PREP, 8'h00);
      wait_idle;
      u_host.cmd(`DFIC_OP_FORMAT, `DFIC_FEAT_FORMAT);
      wait_idle;
      chk(n_pulse, 8);
      rd(`DFIC_OFF_ERROR);
      chk(r[2], 1'b0);
      rd(`DFIC_OFF_MEDIA);
      chk(r[31:16], 16'h0000);
      chk(r[15:0], ra);
      rd(`DFIC_OFF_IRQ_STAT);
      chk(r[1:0], 2'b01);
      results;
   end
endmodule
`default_nettype wire
